// ---- bit_tick_gen.sv ----
// fractional divider giving one enable pulse per full-speed bit time
// assumes the step is below the modulus so at most one pulse per clock
`timescale 1ns/1ps
`default_nettype none
module bit_tick_gen #(
  parameter int          W    = 8,
  parameter logic [W-1:0] MOD = '0,
  parameter logic [W-1:0] STEP = '0
) (
  input  wire logic i_ref_clk,
  input  wire logic i_srst,
  output logic      o_tick
);

  logic [W-1:0] phase_ff;
  logic [W-1:0] nxt_phase;
  logic         tick_ff;
  logic         nxt_tick;
  logic [W:0]   sum;

  // phase accumulator, wraps at the modulus and flags a tick
  always_comb begin
    sum = {1'b0, phase_ff} + {1'b0, STEP};
    if (sum >= {1'b0, MOD}) begin
      nxt_phase = W'(sum - {1'b0, MOD});
      nxt_tick  = 1'b1;
    end else begin
      nxt_phase = sum[W-1:0];
      nxt_tick  = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      phase_ff <= '0;
      tick_ff  <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      tick_ff  <= nxt_tick;
    end
  end

  assign o_tick = tick_ff;

endmodule
`default_nettype wire

// ---- frame_number_periodic_start.sv ----
// frame number counter, frame-left down counter and periodic-start threshold
// assumes the frame length value and handshakes come from the rest of the controller
// Notes on behaviour
// - The frame count goes up by one when the frame-left counter reloads at a boundary, except in a cycle with a software write to it.
// - The frame count rolls over from its top value to zero.
// - The frame count goes up by one on entry into the running state.
// - At each boundary the new count is written to host memory after the start token and before the first descriptor fetch.
// - When that memory write completes the frame start flag is set.
// - The frame count register gives software a 16-bit timing reference.
// - Hardware reset clears the periodic-start threshold.
// - Reaching the threshold gives periodic work priority over control and bulk work.
// - A control or bulk transaction already running finishes before periodic work starts.
// - The frame-left counter counts down each bit time and reloads after zero, marking the boundary.
// - Entry into the running state reloads the frame-left counter from the frame length.
`timescale 1ns/1ps
`default_nettype none
module frame_number_periodic_start (
  input  wire logic        i_ref_clk,
  input  wire logic        i_srst,
  // register port
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  output logic [31:0]      o_reg_rdata,
  output logic             o_reg_rvalid,
  // controller state and frame length
  input  wire logic        i_running_state,
  input  wire logic [13:0] i_frame_length_value,
  output logic [13:0]      o_frame_left_count,
  output logic             o_frame_boundary,
  // frame start sequence
  input  wire logic        i_sof_sent,
  output logic             o_hcca_wr_req,
  output logic [15:0]      o_hcca_wr_data,
  input  wire logic        i_hcca_wr_done,
  output logic             o_frame_start_flag_set,
  output logic             o_ed_fetch_ok,
  // list scheduling
  input  wire logic        i_async_busy,
  output logic             o_periodic_priority,
  output logic             o_periodic_list_go
);

  // ************************************************************
  // bit time enable
  // ************************************************************
  logic bit_tick;

  bit_tick_gen #(
    .W    (frame_timing_pkg::PHASE_W),
    .MOD  (frame_timing_pkg::PHASE_MOD),
    .STEP (frame_timing_pkg::PHASE_STEP)
  ) u_bit_tick (
    .i_ref_clk (i_ref_clk),
    .i_srst    (i_srst),
    .o_tick    (bit_tick)
  );

  // ************************************************************
  // state declarations
  // ************************************************************
  logic [15:0]                  frame_count_value_ff;
  logic [15:0]                  nxt_frame_count_value;
  logic [13:0]                  frame_left_count_ff;
  logic [13:0]                  nxt_frame_left_count;
  logic [13:0]                  threshold_ff;
  logic [13:0]                  nxt_threshold;
  logic                         running_ff;
  logic                         boundary_ff;
  logic                         nxt_boundary;
  logic                         prio_ff;
  logic                         nxt_prio;
  frame_timing_pkg::frame_seq_t seq_ff;
  frame_timing_pkg::frame_seq_t nxt_seq;
  logic [15:0]                  wr_data_ff;
  logic [15:0]                  nxt_wr_data;
  logic                         flag_ff;
  logic                         nxt_flag;
  logic [31:0]                  rdata_ff;
  logic [31:0]                  nxt_rdata;
  logic                         rvalid_ff;
  logic                         run_entry;
  logic                         reload;
  logic                         wr_count;
  logic                         wr_thresh;

  assign run_entry = i_running_state & ~running_ff;
  assign reload    = i_running_state & bit_tick & (frame_left_count_ff == '0);

  // address decode for writes
  always_comb begin
    wr_count  = 1'b0;
    wr_thresh = 1'b0;
    if (i_reg_wr && i_reg_addr == frame_timing_pkg::FRAME_COUNT_OFS) begin
      wr_count = 1'b1;
    end else if (i_reg_wr && i_reg_addr == frame_timing_pkg::PERIODIC_BEGIN_OFS) begin
      wr_thresh = 1'b1;
    end
  end

  // ************************************************************
  // frame-left counter and frame count
  // ************************************************************
  // count down per bit time, reload after zero or on entry to running
  always_comb begin
    nxt_frame_left_count = frame_left_count_ff;
    nxt_boundary         = 1'b0;
    if (run_entry) begin
      nxt_frame_left_count = i_frame_length_value;
    end else if (reload) begin
      nxt_frame_left_count = i_frame_length_value;
      nxt_boundary         = 1'b1;
    end else if (i_running_state && bit_tick) begin
      nxt_frame_left_count = frame_left_count_ff - frame_timing_pkg::FRAME_LEFT_ONE;
    end
  end

  // frame count: software write, else step on reload or on running entry
  always_comb begin
    nxt_frame_count_value = frame_count_value_ff;
    if (wr_count) begin
      nxt_frame_count_value = i_reg_wdata[15:0];
    end else if (reload || run_entry) begin
      // plain 16-bit add wraps from top value back to zero
      nxt_frame_count_value = frame_count_value_ff + frame_timing_pkg::FRAME_COUNT_ONE;
    end
  end

  // threshold register, reserved bits dropped
  always_comb begin
    nxt_threshold = threshold_ff;
    if (wr_thresh) begin
      nxt_threshold = i_reg_wdata[13:0];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      frame_left_count_ff  <= frame_timing_pkg::FRAME_LEFT_RST;
      frame_count_value_ff <= frame_timing_pkg::FRAME_COUNT_RST;
      threshold_ff         <= frame_timing_pkg::THRESHOLD_RST;
      running_ff           <= 1'b0;
      boundary_ff          <= 1'b0;
    end else begin
      frame_left_count_ff  <= nxt_frame_left_count;
      frame_count_value_ff <= nxt_frame_count_value;
      threshold_ff         <= nxt_threshold;
      running_ff           <= i_running_state;
      boundary_ff          <= nxt_boundary;
    end
  end

  // ************************************************************
  // periodic priority
  // ************************************************************
  // set at or below threshold, held until the next boundary or until the running state is left
  always_comb begin
    nxt_prio = prio_ff;
    if (!i_running_state || run_entry || reload) begin
      nxt_prio = 1'b0;
    end else if (frame_left_count_ff <= threshold_ff) begin
      nxt_prio = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      prio_ff <= 1'b0;
    end else begin
      prio_ff <= nxt_prio;
    end
  end

  // periodic list waits for the running control or bulk transaction
  assign o_periodic_list_go = prio_ff & ~i_async_busy;

  // ************************************************************
  // frame start sequence
  // ************************************************************
  // after the boundary: wait for start token, write count, then flag
  always_comb begin
    nxt_seq     = seq_ff;
    nxt_wr_data = wr_data_ff;
    nxt_flag    = 1'b0;
    case (seq_ff)
      frame_timing_pkg::SEQ_IDLE: begin
        if (boundary_ff) begin
          nxt_seq = frame_timing_pkg::SEQ_WAIT_SOF;
        end
      end
      frame_timing_pkg::SEQ_WAIT_SOF: begin
        if (i_sof_sent) begin
          nxt_seq     = frame_timing_pkg::SEQ_WRITE;
          nxt_wr_data = frame_count_value_ff;
        end
      end
      frame_timing_pkg::SEQ_WRITE: begin
        if (i_hcca_wr_done) begin
          nxt_seq  = frame_timing_pkg::SEQ_IDLE;
          nxt_flag = 1'b1;
        end
      end
      default: begin
        nxt_seq = frame_timing_pkg::SEQ_IDLE;
      end
    endcase
    if (boundary_ff && seq_ff != frame_timing_pkg::SEQ_IDLE) begin
      nxt_seq = frame_timing_pkg::SEQ_WAIT_SOF; // a late sequence restarts
    end
    if (!i_running_state) begin
      nxt_seq = frame_timing_pkg::SEQ_IDLE;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      seq_ff     <= frame_timing_pkg::SEQ_IDLE;
      wr_data_ff <= frame_timing_pkg::FRAME_COUNT_RST;
      flag_ff    <= 1'b0;
    end else begin
      seq_ff     <= nxt_seq;
      wr_data_ff <= nxt_wr_data;
      flag_ff    <= nxt_flag;
    end
  end

  // descriptor fetch held off until the count reaches host memory
  assign o_hcca_wr_req  = (seq_ff == frame_timing_pkg::SEQ_WRITE);
  assign o_ed_fetch_ok  = (seq_ff == frame_timing_pkg::SEQ_IDLE) & ~boundary_ff;

  // ************************************************************
  // register read port
  // ************************************************************
  // one-cycle read latency, reserved bits and unmapped offsets read zero
  // read data holds its last value between reads
  always_comb begin
    nxt_rdata = rdata_ff;
    if (i_reg_rd) begin
      if (i_reg_addr == frame_timing_pkg::FRAME_COUNT_OFS) begin
        nxt_rdata = {16'h0000, frame_count_value_ff};
      end else if (i_reg_addr == frame_timing_pkg::PERIODIC_BEGIN_OFS) begin
        nxt_rdata = {18'h00000, threshold_ff};
      end else begin
        nxt_rdata = frame_timing_pkg::READ_NONE;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      rdata_ff  <= frame_timing_pkg::READ_NONE;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= i_reg_rd;
    end
  end

  assign o_reg_rdata            = rdata_ff;
  assign o_reg_rvalid           = rvalid_ff;
  assign o_frame_left_count     = frame_left_count_ff;
  assign o_frame_boundary       = boundary_ff;
  assign o_hcca_wr_data         = wr_data_ff;
  assign o_frame_start_flag_set = flag_ff;
  assign o_periodic_priority    = prio_ff;

endmodule
`default_nettype wire

// ---- frame_number_periodic_start_chk.sv ----
// checker for the frame timing block, bound to its top module
// assumes only the ports of frame_number_periodic_start are visible
`timescale 1ns/1ps
`default_nettype none
module frame_number_periodic_start_chk (
  input wire logic        i_ref_clk,
  input wire logic        i_srst,
  input wire logic        i_reg_rd,
  input wire logic        o_reg_rvalid,
  input wire logic        i_running_state,
  input wire logic [13:0] i_frame_length_value,
  input wire logic [13:0] o_frame_left_count,
  input wire logic        o_frame_boundary,
  input wire logic        i_sof_sent,
  input wire logic        o_hcca_wr_req,
  input wire logic [15:0] o_hcca_wr_data,
  input wire logic        i_hcca_wr_done,
  input wire logic        o_frame_start_flag_set,
  input wire logic        o_ed_fetch_ok,
  input wire logic        i_async_busy,
  input wire logic        o_periodic_priority,
  input wire logic        o_periodic_list_go
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  // ************************************************************
  // frame start sequence
  // ************************************************************
  sequence s_wr_done;
    o_hcca_wr_req && i_hcca_wr_done;
  endsequence
  property p_flag_after_write;
    s_wr_done |=> o_frame_start_flag_set && !o_hcca_wr_req;
  endproperty
  a_flag_after_write: assert property (p_flag_after_write) else $error("flag late");
  a_flag_has_cause: assert property (o_frame_start_flag_set |-> $past(o_hcca_wr_req && i_hcca_wr_done))
    else $error("flag without write");
  a_write_after_sof: assert property ($rose(o_hcca_wr_req) |-> $past(i_sof_sent))
    else $error("write before token");
  a_fetch_held_off: assert property ((o_frame_boundary || o_hcca_wr_req) |-> !o_ed_fetch_ok)
    else $error("fetch allowed early");
  a_wdata_steady: assert property (o_hcca_wr_req && $past(o_hcca_wr_req) |-> $stable(o_hcca_wr_data))
    else $error("write data moved");

  // ************************************************************
  // frame-left counter, priority and read valid
  // ************************************************************
  a_boundary_reload: assert property (o_frame_boundary |->
    o_frame_left_count == i_frame_length_value && !o_periodic_priority)
    else $error("bad reload");
  a_count_down_one: assert property ($past(i_running_state) && $past(i_running_state, 2)
    && !o_frame_boundary && $changed(o_frame_left_count)
    |-> o_frame_left_count == 14'($past(o_frame_left_count) - 14'h0001))
    else $error("bad decrement");
  a_list_go_gate: assert property (o_periodic_list_go == (o_periodic_priority && !i_async_busy))
    else $error("list go wrong");
  a_rvalid_after_rd: assert property (i_reg_rd |=> o_reg_rvalid) else $error("no rvalid");
  a_rvalid_cause: assert property (o_reg_rvalid |-> $past(i_reg_rd))
    else $error("stray rvalid");
endmodule

bind frame_number_periodic_start frame_number_periodic_start_chk chk (
  .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_reg_rd(i_reg_rd), .o_reg_rvalid(o_reg_rvalid),
  .i_running_state(i_running_state), .i_frame_length_value(i_frame_length_value),
  .o_frame_left_count(o_frame_left_count), .o_frame_boundary(o_frame_boundary),
  .i_sof_sent(i_sof_sent), .o_hcca_wr_req(o_hcca_wr_req), .o_hcca_wr_data(o_hcca_wr_data),
  .i_hcca_wr_done(i_hcca_wr_done), .o_frame_start_flag_set(o_frame_start_flag_set),
  .o_ed_fetch_ok(o_ed_fetch_ok), .i_async_busy(i_async_busy),
  .o_periodic_priority(o_periodic_priority), .o_periodic_list_go(o_periodic_list_go));
`default_nettype wire

// ---- frame_timing_pkg.sv ----
// frame timing package: register map, field layout, reset values and timing constants
// assumes a single 250 MHz reference clock and a 12 Mbit/s full-speed bit time
package frame_timing_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam int          ADDR_W               = 8;
  localparam int          DATA_W               = 32;
  localparam logic [7:0]  FRAME_COUNT_OFS      = 8'h3C;
  localparam logic [7:0]  PERIODIC_BEGIN_OFS   = 8'h40;

  // ************************************************************
  // field layout and reset values
  // ************************************************************
  localparam int          FRAME_COUNT_W        = 16;
  localparam int          FRAME_LEFT_W         = 14;
  localparam int          THRESHOLD_W          = 14;
  localparam logic [15:0] FRAME_COUNT_RST      = 16'h0000;
  localparam logic [15:0] FRAME_COUNT_ONE      = 16'h0001;
  localparam logic [13:0] THRESHOLD_RST        = 14'h0000;
  localparam logic [13:0] FRAME_LEFT_RST       = 14'h0000;
  localparam logic [13:0] FRAME_LEFT_ONE       = 14'h0001;
  localparam logic [31:0] READ_NONE            = 32'h0000_0000;

  // ************************************************************
  // timing: bit time derived from the reference clock
  // ************************************************************
  localparam int          REF_CLK_MHZ          = 250;
  localparam int          BIT_RATE_MHZ         = 12;
  localparam int          PHASE_W              = 8;
  localparam logic [7:0]  PHASE_MOD            = 8'(REF_CLK_MHZ);
  localparam logic [7:0]  PHASE_STEP           = 8'(BIT_RATE_MHZ);

  // ************************************************************
  // frame start sequence states
  // ************************************************************
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_WAIT_SOF,
    SEQ_WRITE
  } frame_seq_t;

endpackage

// ---- hcca_model.sv ----
// model of the controller side: start token sender and host memory writer
// assumes the block's clock; drives its outputs at the falling edge
`timescale 1ns/1ps
`default_nettype none
module hcca_model #(
  parameter int DELAY = 3
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_srst,
  input  wire logic        i_frame_boundary,
  input  wire logic        i_wr_req,
  input  wire logic [15:0] i_wr_data,
  output logic             o_sof_sent,
  output logic             o_wr_done,
  output logic [15:0]      o_last_data
);
  int sof_cnt;
  int wr_cnt;
  // token a few cycles after each boundary, then a slow memory acknowledge
  // each output is assigned once per edge so no strobe is written twice
  always @(negedge i_ref_clk) begin
    if (i_srst) begin
      sof_cnt     <= 0;
      wr_cnt      <= 0;
      o_sof_sent  <= 1'b0;
      o_wr_done   <= 1'b0;
      o_last_data <= 16'h0000;
    end else begin
      o_sof_sent <= (sof_cnt == 1) && !i_frame_boundary;
      if (i_frame_boundary) begin
        sof_cnt <= DELAY;
      end else if (sof_cnt != 0) begin
        sof_cnt <= sof_cnt - 1;
      end
      if (i_wr_req && !o_wr_done && wr_cnt == DELAY) begin
        o_wr_done   <= 1'b1;
        o_last_data <= i_wr_data;
        wr_cnt      <= 0;
      end else begin
        o_wr_done <= 1'b0;
        if (i_wr_req && !o_wr_done) begin
          wr_cnt <= wr_cnt + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// testbench for the frame timing block: register access, frame count and priority
// assumes the hcca_model partner and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        i_ref_clk, i_srst, i_reg_wr, i_reg_rd, i_running_state, i_async_busy;
  logic [7:0]  i_reg_addr;
  logic [31:0] i_reg_wdata, o_reg_rdata;
  logic [13:0] i_frame_length_value, o_frame_left_count;
  logic        o_reg_rvalid, o_frame_boundary, i_sof_sent, o_hcca_wr_req, i_hcca_wr_done;
  logic        o_frame_start_flag_set, o_ed_fetch_ok, o_periodic_priority, o_periodic_list_go;
  logic [15:0] o_hcca_wr_data, last_data;
  int          fail_count = 0;
  int          n_compared = 0;

  frame_number_periodic_start dut (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid), .i_running_state(i_running_state),
    .i_frame_length_value(i_frame_length_value), .o_frame_left_count(o_frame_left_count),
    .o_frame_boundary(o_frame_boundary), .i_sof_sent(i_sof_sent),
    .o_hcca_wr_req(o_hcca_wr_req), .o_hcca_wr_data(o_hcca_wr_data),
    .i_hcca_wr_done(i_hcca_wr_done), .o_frame_start_flag_set(o_frame_start_flag_set),
    .o_ed_fetch_ok(o_ed_fetch_ok), .i_async_busy(i_async_busy),
    .o_periodic_priority(o_periodic_priority), .o_periodic_list_go(o_periodic_list_go));
  hcca_model model (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_frame_boundary(o_frame_boundary),
    .i_wr_req(o_hcca_wr_req), .i_wr_data(o_hcca_wr_data), .o_sof_sent(i_sof_sent),
    .o_wr_done(i_hcca_wr_done), .o_last_data(last_data));

  // ************************************************************
  // clock, compare and access tasks
  // ************************************************************
  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    @(negedge i_ref_clk);
    i_reg_wr = 1'b1;
    i_reg_addr = addr;
    i_reg_wdata = data;
    @(negedge i_ref_clk);
    i_reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] addr, input logic [31:0] exp);
    @(negedge i_ref_clk);
    i_reg_rd = 1'b1;
    i_reg_addr = addr;
    @(negedge i_ref_clk);
    i_reg_rd = 1'b0;
    chk_bit(o_reg_rvalid, 1'b1);
    chk(o_reg_rdata, exp);
  endtask
  // waits for boundary (0), priority (1) or flag set (2), bounded
  task automatic wait_on(input int sel);
    int n;
    for (n = 0; n < 2000; n++) begin
      if ((sel == 0 ? o_frame_boundary : sel == 1 ? o_periodic_priority
           : o_frame_start_flag_set) === 1'b1) break;
      @(negedge i_ref_clk);
    end
    if (n == 2000) chk(32'(sel), 32'hFFFF_FFFF);
  endtask

  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial begin
    {i_reg_wr, i_reg_rd, i_running_state, i_async_busy} = 4'h0;
    i_reg_addr = 8'h00;
    i_reg_wdata = 32'h0000_0000;
    i_frame_length_value = 14'h0009;
    i_srst = 1'b1;
    repeat (2) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    i_srst = 1'b0;
    rd(8'h3C, 32'h0000_0000);
    rd(8'h40, 32'h0000_0000);
    rd(8'h44, 32'h0000_0000);
    wr(8'h40, 32'h0000_3E67);
    rd(8'h40, 32'h0000_3E67);
    wr(8'h40, 32'h0000_0004);
    rd(8'h40, 32'h0000_0004);
    wr(8'h3C, 32'h0000_FFFE);
    rd(8'h3C, 32'h0000_FFFE);
    @(negedge i_ref_clk);
    i_running_state = 1'b1;
    rd(8'h3C, 32'h0000_FFFF);
    i_async_busy = 1'b1;
    wait_on(0);
    chk(32'(o_frame_left_count), 32'h0000_0009);
    rd(8'h3C, 32'h0000_0000);
    wait_on(2);
    chk(32'(last_data), 32'h0000_0000);
    chk_bit(o_ed_fetch_ok, 1'b1);
    wait_on(1);
    chk(32'(o_frame_left_count), 32'h0000_0004);
    chk_bit(o_periodic_list_go, 1'b0);
    i_async_busy = 1'b0;
    #1 chk_bit(o_periodic_list_go, 1'b1);
    wait_on(0);
    chk_bit(o_periodic_priority, 1'b0);
    rd(8'h3C, 32'h0000_0001);
    // leave running with priority up, then come back in
    wait_on(1);
    i_running_state = 1'b0;
    @(negedge i_ref_clk);
    chk_bit(o_periodic_priority, 1'b0);
    i_running_state = 1'b1;
    @(negedge i_ref_clk);
    chk(32'(o_frame_left_count), 32'h0000_0009);
    rd(8'h3C, 32'h0000_0002);
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    fail_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
